// file: core/pcfg_params.svh
// constants of the configuration header register group
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH

// register byte offsets in configuration space
`define PCFG_OFS_CLASS      8'h08
`define PCFG_OFS_HOLD       8'h0C
`define PCFG_OFS_IO         8'h10
`define PCFG_OFS_MEM        8'h14
`define PCFG_OFS_SID        8'h2C

// fixed class word fields
`define PCFG_CATEGORY       8'h02
`define PCFG_SUBCATEGORY    8'h00
`define PCFG_SW_LEVEL       8'h00

// field positions
`define PCFG_IO_START_LSB   8
`define PCFG_MEM_START_LSB  12
`define PCFG_HOLD_LSB       8
`define PCFG_LINE_LSB       0
`define PCFG_PRODUCT_LSB    16
`define PCFG_IO_FLAG_BIT    0

// hard reset values
`define PCFG_HOLD_RESET     32'h00000000
`define PCFG_IO_RESET       32'h00000001
`define PCFG_MEM_RESET      32'h00000000

// bus-master command codes
`define PCFG_CMD_MEM_READ   4'h6
`define PCFG_CMD_MEM_WRITE  4'h7

`endif

// file: core/pcfg_pkg.sv
// types and shared helpers of the configuration header register group
`include "pcfg_params.svh"
package pcfg_pkg;

    // register selected by a configuration cycle
    typedef enum {
        SEL_NONE, SEL_CLASS, SEL_HOLD, SEL_IO, SEL_MEM, SEL_SID
    } pcfg_sel_t;

    // whole state of the register module
    typedef struct packed {
        logic [23:0] io_start;   // io window base, bits 31..8
        logic [19:0] mem_start;  // memory window base, bits 31..12
        logic [7:0]  hold;       // bus hold clocks
        logic [7:0]  line_len;   // line length, stored only
        logic [31:0] sid;        // board ident word
        logic [31:0] rdata;      // read answer
        logic        done;       // answer strobe
        logic        claim;      // offset belongs here
        logic        io_hit;     // io window hit
        logic        mem_hit;    // memory window hit
        logic        dma_go;     // master start pulse
        logic [3:0]  dma_cmd;    // master command code
    } pcfg_state_t;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge_be(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_be

    // upper-bit window compare against a base
    function automatic logic win_match(
        input logic [31:0] addr,
        input logic [31:0] base,
        input logic [31:0] keep
    );
        return ((addr & keep) == (base & keep));
    endfunction : win_match

endpackage : pcfg_pkg

// file: core/pcfg_target_decode.sv
// target address decode against the io and memory windows
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_params.svh"
module pcfg_target_decode (
    // target request
    input  wire logic        tgt_valid,
    input  wire logic        tgt_space_io,
    input  wire logic [31:0] tgt_addr,
    // window state
    input  wire logic [31:0] io_base,
    input  wire logic [31:0] mem_base,
    input  wire logic        io_decode_enable,
    input  wire logic        mem_decode_enable,
    // raw hits
    output logic             io_hit_raw,
    output logic             mem_hit_raw
);
    localparam logic [31:0] IO_KEEP  = ~32'h000000FF;  // 256-byte window
    localparam logic [31:0] MEM_KEEP = ~32'h00000FFF;  // 4096-byte window

    // a disabled space never claims, whatever the base holds
    always_comb begin
        io_hit_raw  = tgt_valid && tgt_space_io && io_decode_enable &&
                      pcfg_pkg::win_match(tgt_addr, io_base, IO_KEEP);
        mem_hit_raw = tgt_valid && !tgt_space_io && mem_decode_enable &&
                      pcfg_pkg::win_match(tgt_addr, mem_base, MEM_KEEP);
    end
endmodule : pcfg_target_decode
`default_nettype wire

// file: core/pcfg_master_issue.sv
// bus-master command choice and start gating
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_params.svh"
module pcfg_master_issue (
    // request from the transfer engine
    input  wire logic       dma_req,
    input  wire logic       dma_write,
    // command register permit
    input  wire logic       initiator_permit,
    // result
    output logic            go_raw,
    output logic [3:0]      cmd_raw
);
    // cache line length has no say in the command chosen
    always_comb begin
        cmd_raw = dma_write ? `PCFG_CMD_MEM_WRITE : `PCFG_CMD_MEM_READ;
        go_raw  = dma_req && initiator_permit;
    end
endmodule : pcfg_master_issue
`default_nettype wire

// file: core/pcfg_regs.sv
// configuration header register group with window decode and master gate
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_params.svh"
module pcfg_regs #(
    // silicon revision, arbitrary value
    parameter logic [7:0]  SILICON_REV   = 8'h5A,
    // board product code default, arbitrary value
    parameter logic [15:0] PRODUCT_CODE  = 16'h1D2B,
    // board maker code default, arbitrary value
    parameter logic [15:0] MAKER_CODE    = 16'h4E71
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,

    // configuration cycle port
    input  wire logic        cfg_req,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_offset,
    input  wire logic [3:0]  cfg_byte_en,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_done,
    output logic             cfg_claim,

    // command register enables
    input  wire logic        io_decode_enable,
    input  wire logic        mem_decode_enable,
    input  wire logic        initiator_permit,

    // serial memory load of board ident
    input  wire logic        sid_load,
    input  wire logic [31:0] sid_load_data,

    // target decode
    input  wire logic        tgt_valid,
    input  wire logic        tgt_space_io,
    input  wire logic [31:0] tgt_addr,
    output logic             io_hit,
    output logic             mem_hit,

    // bus-master issue
    input  wire logic        dma_req,
    input  wire logic        dma_write,
    output logic             dma_start,
    output logic [3:0]       dma_cmd,

    // stored control fields
    output logic [7:0]       bus_hold_clocks,
    output logic [31:0]      io_window_start,
    output logic [31:0]      mem_window_start
);

    // ************************************************************
    // hard reset images
    // ************************************************************

    // whole reset words, so fields are cut from them by position and
    // a change of reset value in a stored field never needs an edit in the logic below
    localparam logic [31:0] HOLD_RST = `PCFG_HOLD_RESET;  // hold word image
    localparam logic [31:0] IO_RST   = `PCFG_IO_RESET;    // io base image, flag bit set
    localparam logic [31:0] MEM_RST  = `PCFG_MEM_RESET;   // memory base image

    // ************************************************************
    // state and working signals
    // ************************************************************

    pcfg_pkg::pcfg_state_t st_reg;    // registered state
    pcfg_pkg::pcfg_state_t st_next;   // next state

    pcfg_pkg::pcfg_sel_t   sel;       // selected register

    logic [31:0] class_word;          // composed class word
    logic [31:0] hold_word;           // composed hold word
    logic [31:0] io_word;             // composed io base word
    logic [31:0] mem_word;            // composed memory base word
    logic [31:0] read_word;           // word at the offset
    logic [31:0] merged;              // write merged by lanes

    logic        io_hit_raw;          // decode result
    logic        mem_hit_raw;         // decode result
    logic        go_raw;              // permitted start
    logic [3:0]  cmd_raw;             // command for the start

    // ************************************************************
    // read-back composition
    // ************************************************************

    // class word is all constant but the revision byte
    always_comb begin
        class_word = {`PCFG_CATEGORY,
                      `PCFG_SUBCATEGORY,
                      `PCFG_SW_LEVEL,
                      SILICON_REV};
    end

    // top bits are tied low so a self-test is never offered
    always_comb begin
        hold_word = {1'b0,
                     1'b0,
                     14'h0000,
                     st_reg.hold,
                     st_reg.line_len};
    end

    // low io bits are tied so sizing reads back a 256-byte span
    always_comb begin
        io_word = {st_reg.io_start,
                   6'h00,
                   1'b0,
                   1'b1};
    end

    // low memory bits are tied so sizing reads back 4096 bytes
    always_comb begin
        mem_word = {st_reg.mem_start,
                    8'h00,
                    1'b0,
                    2'b00,
                    1'b0};
    end

    // ************************************************************
    // offset decode
    // ************************************************************

    // full-byte compare; offsets outside the group are not claimed
    always_comb begin
        case (cfg_offset)
            `PCFG_OFS_CLASS: begin
                sel = pcfg_pkg::SEL_CLASS;
            end
            `PCFG_OFS_HOLD: begin
                sel = pcfg_pkg::SEL_HOLD;
            end
            `PCFG_OFS_IO: begin
                sel = pcfg_pkg::SEL_IO;
            end
            `PCFG_OFS_MEM: begin
                sel = pcfg_pkg::SEL_MEM;
            end
            `PCFG_OFS_SID: begin
                sel = pcfg_pkg::SEL_SID;
            end
            default: begin
                sel = pcfg_pkg::SEL_NONE;
            end
        endcase
    end

    // word seen at the offset, zero when unclaimed
    always_comb begin
        case (sel)
            pcfg_pkg::SEL_CLASS: begin
                read_word = class_word;
            end
            pcfg_pkg::SEL_HOLD: begin
                read_word = hold_word;
            end
            pcfg_pkg::SEL_IO: begin
                read_word = io_word;
            end
            pcfg_pkg::SEL_MEM: begin
                read_word = mem_word;
            end
            pcfg_pkg::SEL_SID: begin
                read_word = st_reg.sid;
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    end

    // merge over the read-back word so tied bits stay tied
    always_comb begin
        merged = pcfg_pkg::merge_be(read_word, cfg_wdata, cfg_byte_en);
    end

    // ************************************************************
    // helpers
    // ************************************************************

    // window compare on the stored bases
    // the tied low bits of each word fall under the compare mask anyway
    pcfg_target_decode u_decode (
        .tgt_valid         (tgt_valid),
        .tgt_space_io      (tgt_space_io),
        .tgt_addr          (tgt_addr),
        .io_base           (io_word),
        .mem_base          (mem_word),
        .io_decode_enable  (io_decode_enable),
        .mem_decode_enable (mem_decode_enable),
        .io_hit_raw        (io_hit_raw),
        .mem_hit_raw       (mem_hit_raw)
    );

    // master command and permit
    pcfg_master_issue u_master (
        .dma_req          (dma_req),
        .dma_write        (dma_write),
        .initiator_permit (initiator_permit),
        .go_raw           (go_raw),
        .cmd_raw          (cmd_raw)
    );

    // ************************************************************
    // next state
    // ************************************************************

    // one place decides every field, reset included
    always_comb begin
        st_next = st_reg;

        // answer strobe lasts one cycle
        st_next.done  = cfg_req;
        st_next.claim = cfg_req && (sel != pcfg_pkg::SEL_NONE);

        // read data is captured on every read request, cleared to zero on a write request, and then held
        if (cfg_req) begin
            st_next.rdata = cfg_write ? 32'h00000000 : read_word;
        end

        // writes reach the stored fields only
        if (cfg_req && cfg_write) begin
            // hold word bits 31..16 have no storage, so writes to them vanish
            case (sel)
                pcfg_pkg::SEL_HOLD: begin
                    st_next.hold     = merged[15:8];
                    st_next.line_len = merged[7:0];
                end
                pcfg_pkg::SEL_IO: begin
                    st_next.io_start = merged[31:8];
                end
                pcfg_pkg::SEL_MEM: begin
                    st_next.mem_start = merged[31:12];
                end
                default: begin
                    // class and ident words ignore writes
                    st_next.hold = st_reg.hold;
                end
            endcase
        end

        // serial memory load replaces the board codes
        // it follows the write path but comes before reset, so a same-cycle hard reset wins over a load
        if (sid_load) begin
            st_next.sid = sid_load_data;
        end

        // decode result one cycle after the target request
        st_next.io_hit  = io_hit_raw;
        st_next.mem_hit = mem_hit_raw;

        // master start pulse, command held until the next start
        st_next.dma_go = go_raw;
        if (go_raw) begin
            st_next.dma_cmd = cmd_raw;
        end

        // hard reset only; there is no soft reset path here, so a soft
        // reset elsewhere in the device leaves every programmed field alone
        if (!rst_n) begin
            // stored fields back to their hard reset images
            st_next.hold      = HOLD_RST[15:8];
            st_next.line_len  = HOLD_RST[7:0];
            st_next.io_start  = IO_RST[31:8];
            st_next.mem_start = MEM_RST[31:12];
            st_next.sid       = {PRODUCT_CODE, MAKER_CODE};
            // answer, decode and master state back to idle
            st_next.rdata     = 32'h00000000;
            st_next.done      = 1'b0;
            st_next.claim     = 1'b0;
            st_next.io_hit    = 1'b0;
            st_next.mem_hit   = 1'b0;
            st_next.dma_go    = 1'b0;
            st_next.dma_cmd   = `PCFG_CMD_MEM_READ;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    // synchronous reset is folded into the next-state logic above
    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end

    // ************************************************************
    // outputs, all straight from the state register
    // ************************************************************

    // configuration answer
    always_comb begin
        cfg_rdata = st_reg.rdata;
        cfg_done  = st_reg.done;
        cfg_claim = st_reg.claim;
    end

    // decode and master results
    always_comb begin
        io_hit    = st_reg.io_hit;
        mem_hit   = st_reg.mem_hit;
        dma_start = st_reg.dma_go;
        dma_cmd   = st_reg.dma_cmd;
    end

    // stored fields for the rest of the device
    // low bits of the window starts are zero, the windows being aligned
    always_comb begin
        bus_hold_clocks  = st_reg.hold;
        io_window_start  = {st_reg.io_start, 8'h00};
        mem_window_start = {st_reg.mem_start, 12'h000};
    end

endmodule : pcfg_regs
`default_nettype wire

// file: verification/pcfg_regs_asserts.sv
// assertion checker for the configuration header register group
`timescale 1ns/100ps
`default_nettype none
module pcfg_regs_asserts (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // configuration port
    input wire logic        cfg_req,
    input wire logic        cfg_write,
    input wire logic [7:0]  cfg_offset,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_done,
    input wire logic        cfg_claim,
    // decode and master
    input wire logic        io_decode_enable,
    input wire logic        mem_decode_enable,
    input wire logic        initiator_permit,
    input wire logic        tgt_valid,
    input wire logic        tgt_space_io,
    input wire logic        io_hit,
    input wire logic        mem_hit,
    input wire logic        dma_req,
    input wire logic        dma_write,
    input wire logic        dma_start,
    input wire logic [3:0]  dma_cmd
);
    // ****************************************
    // properties, all in the one clock domain
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire rd_q = cfg_req && !cfg_write;  // read request this cycle

    property p_answer; cfg_req |=> cfg_done; endproperty
    a_answer: assert property (p_answer) else $error("no answer after request");
    property p_claim; cfg_claim |-> cfg_done; endproperty
    a_claim: assert property (p_claim) else $error("claim without answer");
    property p_class; rd_q && cfg_offset == 8'h08 |=> cfg_rdata[31:8] == 24'h020000; endproperty
    a_class: assert property (p_class) else $error("class word wrong");
    property p_hold; rd_q && cfg_offset == 8'h0C |=> cfg_rdata[31:16] == 16'h0000; endproperty
    a_hold: assert property (p_hold) else $error("hold word top not zero");
    property p_io_low; rd_q && cfg_offset == 8'h10 |=> cfg_rdata[7:0] == 8'h01; endproperty
    a_io_low: assert property (p_io_low) else $error("io low byte wrong");
    property p_mem_low; rd_q && cfg_offset == 8'h14 |=> cfg_rdata[11:0] == 12'h000; endproperty
    a_mem_low: assert property (p_mem_low) else $error("mem low bits wrong");
    property p_io_gate; !(tgt_valid && tgt_space_io && io_decode_enable) |=> !io_hit; endproperty
    a_io_gate: assert property (p_io_gate) else $error("io hit not allowed");
    property p_mem_gate; !(tgt_valid && !tgt_space_io && mem_decode_enable) |=> !mem_hit;
    endproperty
    a_mem_gate: assert property (p_mem_gate) else $error("mem hit not allowed");
    property p_master;
        dma_req && initiator_permit |=> dma_start && dma_cmd == {3'b011, $past(dma_write)};
    endproperty
    a_master: assert property (p_master) else $error("start or command wrong");
    property p_no_start; !(dma_req && initiator_permit) |=> !dma_start && $stable(dma_cmd);
    endproperty
    a_no_start: assert property (p_no_start) else $error("start without permit");
    property p_rdata_hold; !cfg_req |=> $stable(cfg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    // main scenarios reached
    c_class: cover property (rd_q && cfg_offset == 8'h08 ##1 cfg_done);
    c_io_hit: cover property (io_hit);
    c_start: cover property (dma_start && dma_cmd == 4'h7);
endmodule : pcfg_regs_asserts

bind pcfg_regs pcfg_regs_asserts chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_offset(cfg_offset), .cfg_rdata(cfg_rdata),
    .cfg_done(cfg_done), .cfg_claim(cfg_claim), .io_decode_enable(io_decode_enable),
    .mem_decode_enable(mem_decode_enable), .initiator_permit(initiator_permit),
    .tgt_valid(tgt_valid), .tgt_space_io(tgt_space_io), .io_hit(io_hit), .mem_hit(mem_hit),
    .dma_req(dma_req), .dma_write(dma_write), .dma_start(dma_start), .dma_cmd(dma_cmd));
`default_nettype wire

// file: verification/pcfg_host_model.sv
// host configuration software model driving configuration cycles
`timescale 1ns/100ps
`default_nettype none
module pcfg_host_model (
    // clock
    input  wire logic        sys_clk,
    // configuration cycle drive
    output logic             cfg_req,
    output logic             cfg_write,
    output logic [7:0]       cfg_offset,
    output logic [3:0]       cfg_byte_en,
    output logic [31:0]      cfg_wdata,
    // device answer
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_done,
    input  wire logic        cfg_claim
);
    // idle bus at time zero
    initial begin
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_offset = 8'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h00000000;
    end

    // one access; software programs hold count and window bases here
    task automatic cfg_access(input logic wr, input logic [7:0] ofs, input logic [3:0] be,
        input logic [31:0] wd, output logic [31:0] rd, output logic claim, output logic ok);
        int n;
        @(posedge sys_clk);
        cfg_req <= 1'b1;
        cfg_write <= wr;
        cfg_offset <= ofs;
        cfg_byte_en <= be;
        cfg_wdata <= wd;
        @(posedge sys_clk);
        cfg_req <= 1'b0;
        // released offset and data lines must not keep their last value
        cfg_offset <= ~ofs;
        cfg_wdata <= ~wd;
        #1;
        n = 0;
        while (cfg_done !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        ok = (n == 0) && (cfg_done === 1'b1);
        rd = cfg_rdata;
        claim = cfg_claim;
    endtask : cfg_access
endmodule : pcfg_host_model
`default_nettype wire

// file: verification/pcfg_regs_test.sv
// self-checking testbench of the configuration header register group
`timescale 1ns/100ps
`default_nettype none
module pcfg_regs_test;
    // ****************************************
    // signals and design
    // ****************************************
    localparam logic [7:0] REV = 8'h5A;         // arbitrary value
    localparam logic [31:0] SID = 32'h1D2B4E71; // arbitrary value
    logic sys_clk, rst_n, cfg_req, cfg_write, cfg_done, cfg_claim;
    logic [7:0] cfg_offset, bus_hold_clocks;
    logic [3:0] cfg_byte_en, dma_cmd;
    logic [31:0] cfg_wdata, cfg_rdata, sid_load_data, tgt_addr, io_window_start, mem_window_start;
    logic io_decode_enable, mem_decode_enable, initiator_permit, sid_load, tgt_valid;
    logic tgt_space_io, io_hit, mem_hit, dma_req, dma_write, dma_start;
    int fail_count, compares, cycles;
    logic [7:0] offs [5] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h2C};
    logic [31:0] exp_rst [5] = '{{24'h020000, REV}, 32'h0, 32'h1, 32'h0, SID};
    logic [31:0] exp_one [5] = '{{24'h020000, REV}, 32'h0000FFFF, 32'hFFFFFF01, 32'hFFFFF000, SID};

    pcfg_regs #(.SILICON_REV(REV), .PRODUCT_CODE(SID[31:16]), .MAKER_CODE(SID[15:0])) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .cfg_claim(cfg_claim),
        .io_decode_enable(io_decode_enable), .mem_decode_enable(mem_decode_enable),
        .initiator_permit(initiator_permit), .sid_load(sid_load), .sid_load_data(sid_load_data),
        .tgt_valid(tgt_valid), .tgt_space_io(tgt_space_io), .tgt_addr(tgt_addr),
        .io_hit(io_hit), .mem_hit(mem_hit), .dma_req(dma_req), .dma_write(dma_write),
        .dma_start(dma_start), .dma_cmd(dma_cmd), .bus_hold_clocks(bus_hold_clocks),
        .io_window_start(io_window_start), .mem_window_start(mem_window_start));
    pcfg_host_model host_u (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .cfg_claim(cfg_claim));

    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // hang guard: the tests need under a hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            fail_count++;
            finish_test();
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] r;
        logic c, ok;
        host_u.cfg_access(1'b1, ofs, be, d, r, c, ok);
        chk({31'h0, ok}, 32'h1);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [31:0] exp, input logic cl);
        logic [31:0] r;
        logic c, ok;
        host_u.cfg_access(1'b0, ofs, 4'hF, 32'h0, r, c, ok);
        chk(r, exp);
        chk({30'h0, c, ok}, {30'h0, cl, 1'b1});
    endtask : rd
    // one target cycle, hit seen one edge later
    task automatic tgt(input logic io, input logic [31:0] a, input logic exp);
        @(posedge sys_clk);
        tgt_valid <= 1'b1;
        tgt_space_io <= io;
        tgt_addr <= a;
        @(posedge sys_clk);
        tgt_valid <= 1'b0;
        tgt_addr <= ~a;
        #1;
        chk({30'h0, io_hit, mem_hit}, {30'h0, io & exp, !io & exp});
    endtask : tgt
    // one master request
    task automatic dma(input logic w, input logic p, input logic [3:0] cmd);
        @(posedge sys_clk);
        dma_req <= 1'b1;
        dma_write <= w;
        initiator_permit <= p;
        @(posedge sys_clk);
        dma_req <= 1'b0;
        #1;
        chk({27'h0, dma_start, dma_cmd}, {27'h0, p, cmd});
    endtask : dma

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n, io_decode_enable, mem_decode_enable, initiator_permit, sid_load} = '0;
        {tgt_valid, tgt_space_io, dma_req, dma_write} = '0;
        {tgt_addr, sid_load_data} = '0;
        {fail_count, compares, cycles} = '0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(offs[i], exp_rst[i], 1'b1);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) wr(offs[i], 4'hF, 32'hFFFFFFFF);
        wr(8'h30, 4'hF, 32'hFFFFFFFF);
        for (int i = 0; i < 5; i++) rd(offs[i], exp_one[i], 1'b1);
        rd(8'h30, 32'h0, 1'b0);
        chk({bus_hold_clocks, io_window_start[31:8]}, 32'hFFFFFFFF);
        chk(mem_window_start, 32'hFFFFF000);
        wr(8'h0C, 4'h2, 32'h0);
        rd(8'h0C, 32'h000000FF, 1'b1);
        $display("test write masks done");
        wr(8'h10, 4'hF, 32'h0000AB00);
        wr(8'h14, 4'hF, 32'h12345000);
        @(posedge sys_clk);
        io_decode_enable <= 1'b1;
        tgt(1'b1, 32'h0000AB7C, 1'b1);
        tgt(1'b1, 32'h0000AC00, 1'b0);
        tgt(1'b0, 32'h12345FFC, 1'b0);
        @(posedge sys_clk);
        mem_decode_enable <= 1'b1;
        tgt(1'b0, 32'h12345FFC, 1'b1);
        tgt(1'b0, 32'h12346000, 1'b0);
        @(posedge sys_clk);
        io_decode_enable <= 1'b0;
        tgt(1'b1, 32'h0000AB00, 1'b0);
        $display("test window decode done");
        dma(1'b0, 1'b1, 4'h6);
        dma(1'b1, 1'b1, 4'h7);
        dma(1'b0, 1'b0, 4'h7);
        $display("test master issue done");
        @(posedge sys_clk);
        sid_load <= 1'b1;
        sid_load_data <= 32'hA5C33C5A;
        @(posedge sys_clk);
        sid_load <= 1'b0;
        wr(8'h2C, 4'hF, 32'h0);
        rd(8'h2C, 32'hA5C33C5A, 1'b1);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h10, 32'h00000001, 1'b1);
        rd(8'h2C, SID, 1'b1);
        $display("test ident load and reset done");
        finish_test();
    end
endmodule : pcfg_regs_test
`default_nettype wire
